// ==== rtl/tpwm_top.sv ====
// Register access over Wishbone and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// - In 16-bit mode the output stays high for n source ticks per period, n the value register.
// - In 16-bit mode the period is fixed at 65535 source ticks.
// - In 8-bit mode the output stays high for n*(m+1) ticks, n the value's upper byte.
// - In 8-bit mode the period is 255*(m+1) ticks, m the value's lower byte.
// - The counter runs on one selectable source: clk, clk/2, clk/8, clk/32 or subclock/32.
// - An interrupt event is raised each time the output falls after its high portion.
module tpwm_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic subclk_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic pwm_o,
    output logic irq_o
);
    import tpwm_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Registers, period engine state and internal strobes
    logic [4:0] ctrl_q;
    logic [15:0] value_q;
    logic stat_q;
    logic mask_q;
    logic sub_s1_q, sub_s2_q, sub_s3_q;
    logic tick;
    logic req;
    tpwm_state_e state_q;
    logic [15:0] main_q;
    logic [7:0] pre_q;
    logic [15:0] hi_q;
    logic [7:0] m_q;
    logic mode8_q;
    logic fall_ev;
    logic stat_rd;

    // Bus request decode; ack masks the request so each access is taken once
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign stat_rd = req && !wb_we_i && (wb_adr_i == TPWM_OFS_STAT);

    // Subclock pin synchroniser and edge detect past the second stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sub_s1_q <= 1'b0;
            sub_s2_q <= 1'b0;
            sub_s3_q <= 1'b0;
        end else if (ce_i) begin
            sub_s1_q <= subclk_i;
            sub_s2_q <= sub_s1_q;
            sub_s3_q <= sub_s2_q;
        end
    end

    tpwm_source_sel u_src (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .run_i(ctrl_q[TPWM_CTRL_RUN]),
        .sel_i(ctrl_q[TPWM_CTRL_SRC_LSB +: TPWM_CTRL_SRC_W]),
        .sub_rise_i(sub_s2_q && !sub_s3_q),
        .tick_o(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave: one-cycle ack, unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            ctrl_q <= TPWM_CTRL_RST;
            value_q <= TPWM_VALUE_RST;
            mask_q <= MTPWM_MASK_RST;
        end else if (ce_i) begin
            wb_ack_o <= req;
            if (req && wb_we_i) begin
                case (wb_adr_i)
                    TPWM_OFS_CTRL: if (wb_sel_i[0]) ctrl_q <= wb_dat_i[4:0];
                    TPWM_OFS_VALUE: begin
                        if (wb_sel_i[0]) value_q[7:0] <= wb_dat_i[7:0];
                        if (wb_sel_i[1]) value_q[15:8] <= wb_dat_i[15:8];
                    end
                    TPWM_OFS_MASK: if (wb_sel_i[0]) mask_q <= wb_dat_i[0];
                    default: ;
                endcase
            end
            if (req && !wb_we_i) begin
                case (wb_adr_i)
                    TPWM_OFS_CTRL: wb_dat_o <= {27'h0, ctrl_q};
                    TPWM_OFS_VALUE: wb_dat_o <= {16'h0, value_q};
                    TPWM_OFS_STAT: wb_dat_o <= {30'h0, pwm_o, stat_q};
                    TPWM_OFS_MASK: wb_dat_o <= {31'h0, mask_q};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Period engine: main counts ticks of the period, prescaler scales by m+1 in 8-bit mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= TPWM_IDLE;
            main_q <= 16'h0000;
            pre_q <= 8'h00;
            hi_q <= 16'h0000;
            m_q <= 8'h00;
            mode8_q <= 1'b0;
            pwm_o <= 1'b0;
            fall_ev <= 1'b0;
        end else if (ce_i) begin
            fall_ev <= 1'b0;
            case (state_q)
                TPWM_IDLE: begin
                    pwm_o <= 1'b0;
                    if (ctrl_q[TPWM_CTRL_RUN]) begin
                        state_q <= TPWM_RUN;
                        main_q <= 16'h0000;
                        pre_q <= 8'h00;
                        // Settings are latched at each period start
                        mode8_q <= ctrl_q[TPWM_CTRL_MODE8];
                        hi_q <= ctrl_q[TPWM_CTRL_MODE8] ? {8'h00, value_q[15:8]} : value_q;
                        m_q <= value_q[7:0];
                        pwm_o <= ctrl_q[TPWM_CTRL_MODE8] ? (value_q[15:8] != 8'h00)
                                                         : (value_q != 16'h0000);
                    end
                end
                TPWM_RUN: begin
                    if (!ctrl_q[TPWM_CTRL_RUN]) begin
                        state_q <= TPWM_IDLE;
                        pwm_o <= 1'b0;
                    end else if (tick) begin
                        if (mode8_q && pre_q != m_q) begin
                            pre_q <= pre_q + 8'h01;
                        end else begin
                            pre_q <= 8'h00;
                            if (main_q + 16'h0001 ==
                                (mode8_q ? {8'h00, TPWM_PERIOD8} : TPWM_PERIOD16)) begin
                                // New period: reload and go high again unless the new high time is zero
                                main_q <= 16'h0000;
                                mode8_q <= ctrl_q[TPWM_CTRL_MODE8];
                                hi_q <= ctrl_q[TPWM_CTRL_MODE8] ? {8'h00, value_q[15:8]}
                                                                : value_q;
                                m_q <= value_q[7:0];
                                pwm_o <= ctrl_q[TPWM_CTRL_MODE8] ? (value_q[15:8] != 8'h00)
                                                                 : (value_q != 16'h0000);
                                if (pwm_o && hi_q >= main_q + 16'h0001) begin
                                    fall_ev <= !(ctrl_q[TPWM_CTRL_MODE8] ?
                                        (value_q[15:8] != 8'h00) : (value_q != 16'h0000));
                                end
                            end else begin
                                main_q <= main_q + 16'h0001;
                                if (pwm_o && main_q + 16'h0001 == hi_q) begin
                                    pwm_o <= 1'b0;
                                    fall_ev <= 1'b1;
                                end
                            end
                        end
                    end
                end
                default: state_q <= TPWM_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky status, cleared by read; a new event wins over the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_q <= 1'b0;
            irq_o <= 1'b0;
        end else if (ce_i) begin
            if (fall_ev) begin
                stat_q <= 1'b1;
            end else if (stat_rd) begin
                stat_q <= 1'b0;
            end
            irq_o <= (fall_ev || (stat_q && !stat_rd)) && mask_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks on the period engine, the status flag and the interrupt line
    chk_fall_sets_stat: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && fall_ev |=> stat_q)
        else $error("fall event did not set status");
    chk_fall_needs_high: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(fall_ev) |-> !pwm_o && $past(pwm_o))
        else $error("fall event without high pulse");
    chk_idle_low: assert property (@(posedge clk_i) disable iff (rst_i)
        state_q == TPWM_IDLE && $past(state_q) == TPWM_IDLE |-> !pwm_o)
        else $error("output high while idle");
    chk_period16_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
        !mode8_q |-> main_q < TPWM_PERIOD16)
        else $error("16-bit counter beyond period");
    chk_period8_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
        mode8_q |-> main_q < {8'h00, TPWM_PERIOD8})
        else $error("8-bit counter beyond period");
    chk_pre_bound: assert property (@(posedge clk_i) disable iff (rst_i)
        mode8_q |-> pre_q <= m_q)
        else $error("prescaler beyond m");
    chk_high_until_n: assert property (@(posedge clk_i) disable iff (rst_i)
        state_q == TPWM_RUN && main_q != 16'h0000 && main_q < hi_q && $stable(main_q)
        |-> pwm_o)
        else $error("output low before high time");
    chk_low_after_n: assert property (@(posedge clk_i) disable iff (rst_i)
        state_q == TPWM_RUN && main_q >= hi_q && main_q != 16'h0000 |-> !pwm_o)
        else $error("output high after high time");
    chk_irq_masked: assert property (@(posedge clk_i) disable iff (rst_i)
        !mask_q && !$past(mask_q) |-> !irq_o)
        else $error("interrupt while masked");
endmodule // tpwm_top

// ==== rtl/tpwm_pkg.sv ====
package tpwm_pkg;
    // Register byte offsets (one 32-bit word each)
    localparam logic [3:0] TPWM_OFS_CTRL = 4'h0;
    localparam logic [3:0] TPWM_OFS_VALUE = 4'h4;
    localparam logic [3:0] TPWM_OFS_STAT = 4'h8;
    localparam logic [3:0] TPWM_OFS_MASK = 4'hC;
    // Control fields
    localparam int TPWM_CTRL_RUN = 0;
    localparam int TPWM_CTRL_MODE8 = 1;
    localparam int TPWM_CTRL_SRC_LSB = 2;
    localparam int TPWM_CTRL_SRC_W = 3;
    // Status bit positions
    localparam int TPWM_STAT_FALL = 0;
    // Reset values
    localparam logic [4:0] TPWM_CTRL_RST = 5'h00;
    localparam logic [15:0] TPWM_VALUE_RST = 16'h0000;
    localparam logic MTPWM_MASK_RST = 1'b0;
    // Count source selections
    localparam logic [2:0] TPWM_SRC_DIV1 = 3'h0;
    localparam logic [2:0] TPWM_SRC_DIV2 = 3'h1;
    localparam logic [2:0] TPWM_SRC_DIV8 = 3'h2;
    localparam logic [2:0] TPWM_SRC_DIV32 = 3'h3;
    localparam logic [2:0] TPWM_SRC_SUB32 = 3'h4;
    // Divider terminal counts (ratio minus one)
    localparam logic [4:0] TPWM_DIV2_LAST = 5'h01;
    localparam logic [4:0] TPWM_DIV8_LAST = 5'h07;
    localparam logic [4:0] TPWM_DIV32_LAST = 5'h1F;
    // Periods in main counter steps; a step is m+1 count-source ticks in 8-bit mode
    localparam logic [15:0] TPWM_PERIOD16 = 16'hFFFF;
    localparam logic [7:0] TPWM_PERIOD8 = 8'hFF;
    typedef enum logic [0:0] {TPWM_IDLE, TPWM_RUN} tpwm_state_e;
endpackage

// ==== rtl/tpwm_source_sel.sv ====
`timescale 1ns/1ps
// Count-source tick generator: one pulse per selected source period
module tpwm_source_sel (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic run_i,
    input wire logic [2:0] sel_i,
    input wire logic sub_rise_i,
    output logic tick_o
);
    import tpwm_pkg::*;
    logic [4:0] div_q;
    logic [4:0] sub_q;
    logic [4:0] last;

    // Terminal count for the chosen divider
    always_comb begin
        case (sel_i)
            TPWM_SRC_DIV2: last = TPWM_DIV2_LAST;
            TPWM_SRC_DIV8: last = TPWM_DIV8_LAST;
            TPWM_SRC_DIV32: last = TPWM_DIV32_LAST;
            default: last = 5'h00;
        endcase
    end

    // Main clock prescaler and subclock divide-by-32
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            div_q <= 5'h00;
            sub_q <= 5'h00;
            tick_o <= 1'b0;
        end else if (ce_i) begin
            if (sel_i == TPWM_SRC_SUB32) begin
                if (sub_rise_i) begin
                    sub_q <= sub_q + 5'h01;
                end
                tick_o <= sub_rise_i && (sub_q == TPWM_DIV32_LAST);
            end else if (sel_i > TPWM_SRC_SUB32) begin
                tick_o <= 1'b0;
            end else begin
                div_q <= (div_q >= last) ? 5'h00 : div_q + 5'h01;
                tick_o <= (div_q >= last);
            end
        end
    end
endmodule // tpwm_source_sel

// ==== sim/tb.sv ====
`timescale 1ns/1ps
module tb;
    import tpwm_pkg::*;
    ////////////////////////////////////////////////////////////////////////////
    logic clk_i, rst_i, subclk, wb_cyc, wb_stb, wb_we, ack, pwm, irq;
    logic [3:0] wb_adr;
    logic [3:0] sub_cnt;
    logic [31:0] wb_dat, dat_o, rd;
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc_cnt = 0;
    int c, lo, hi;
    // Device under test, byte lanes and clock enable held on
    tpwm_top tpwm_top_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .subclk_i(subclk),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .pwm_o(pwm), .irq_o(irq));
    ////////////////////////////////////////////////////////////////////////////
    // System clock, 8 ns period
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // Slow subclock, one rising edge every 16 system cycles
    always @(posedge clk_i) begin
        sub_cnt <= sub_cnt + 4'h1;
        subclk <= sub_cnt[3];
    end
    // Hang guard, ceiling above the sum of all periods measured
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 90000) begin
            n_mismatch++;
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("Counts: %0d checks, %0d mismatches", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // One classic single cycle; read data lands in rd at the ack edge
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        rd = dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    // Count cycles until the output reaches the given level
    task automatic run_to(input logic v, output int n);
        n = 0;
        while (pwm !== v) begin
            @(posedge clk_i);
            n++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Reset values, write-back and an unmapped address
    task automatic t_regs();
        wb(1'b0, TPWM_OFS_CTRL, 32'h0);
        chk(rd, 32'h00000000);
        wb(1'b0, TPWM_OFS_VALUE, 32'h0);
        chk(rd, 32'h00000000);
        wb(1'b1, TPWM_OFS_VALUE, 32'h0000A5C3);
        wb(1'b0, TPWM_OFS_VALUE, 32'h0);
        chk(rd, 32'h0000A5C3);
        wb(1'b1, 4'h2, 32'hFFFFFFFF);
        wb(1'b0, 4'h2, 32'h0);
        chk(rd, 32'h00000000);
        wb(1'b0, TPWM_OFS_MASK, 32'h0);
        chk(rd, 32'h00000000);
        $display("Test regs done");
    endtask
    // Run one setting; measure the first pulse and the period that it opens
    task automatic t_pwm(input logic m8, input logic [2:0] src, input logic [15:0] val,
                         input int exp_hi, input int exp_per);
        wb(1'b1, TPWM_OFS_VALUE, {16'h0000, val});
        wb(1'b1, TPWM_OFS_CTRL, {27'h0, src, m8, 1'b1});
        run_to(1'b1, c);
        run_to(1'b0, hi);
        run_to(1'b1, lo);
        chk(32'(hi), 32'(exp_hi));
        chk(32'(lo + hi), 32'(exp_per));
        wb(1'b1, TPWM_OFS_CTRL, 32'h0);
        repeat (2) @(posedge clk_i);
        chk({31'h0, pwm}, 32'h0);
        $display("Test pwm src %0d mode8 %0d done", src, m8);
    endtask
    // Unmasked fall raises the line; a status read clears it
    task automatic t_irq();
        wb(1'b1, TPWM_OFS_MASK, 32'h1);
        t_pwm(1'b1, TPWM_SRC_DIV1, 16'h0301, 6, 510);
        chk({31'h0, irq}, 32'h1);
        wb(1'b0, TPWM_OFS_STAT, 32'h0);
        chk({31'h0, rd[TPWM_STAT_FALL]}, 32'h1);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq}, 32'h0);
        wb(1'b1, TPWM_OFS_MASK, 32'h0);
        $display("Test irq done");
    endtask
    // Subclock source: first pulse of one tick, phase of the subclock unknown
    task automatic t_sub();
        wb(1'b1, TPWM_OFS_VALUE, 32'h00000100);
        wb(1'b1, TPWM_OFS_CTRL, {27'h0, TPWM_SRC_SUB32, 2'b11});
        run_to(1'b1, c);
        run_to(1'b0, hi);
        chk({31'h0, (hi >= 480 && hi <= 544)}, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wb(1'b0, TPWM_OFS_STAT, 32'h0);
        chk({31'h0, rd[TPWM_STAT_FALL]}, 32'h1);
        wb(1'b1, TPWM_OFS_CTRL, 32'h0);
        // Unused source code gives no ticks: the output stays high
        wb(1'b1, TPWM_OFS_CTRL, {27'h0, 3'h5, 2'b01});
        repeat (40) @(posedge clk_i);
        chk({31'h0, pwm}, 32'h1);
        wb(1'b1, TPWM_OFS_CTRL, 32'h0);
        $display("Test subclock done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst_i = 1'b1;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 4'h0;
        wb_dat = 32'h0;
        subclk = 1'b0;
        sub_cnt = 4'h0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_irq();
        t_pwm(1'b1, TPWM_SRC_DIV2, 16'h0200, 4, 510);
        t_pwm(1'b1, TPWM_SRC_DIV8, 16'h0200, 16, 2040);
        t_pwm(1'b1, TPWM_SRC_DIV32, 16'h0200, 64, 8160);
        t_pwm(1'b0, TPWM_SRC_DIV1, 16'h0005, 5, 65535);
        t_sub();
        final_report();
    end
endmodule // tb
